// ===== hdl/wwd_timing_regs.sv
// Window watchdog timing, signature check and reset delay with an AXI4-Lite slave
`timescale 1ns/1ns
module wwd_timing_regs
    import wwd_pkg::*;
#(
    parameter int SEQ_WIDTH = WWD_SEQ_WIDTH_DEF
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // AXI4-Lite write address and data
    input  wire logic [WWD_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read
    input  wire logic [WWD_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Watchdog outputs
    output logic                       wdt_interrupt,
    output logic                       wdt_reset,
    output logic                       second_window
);

    localparam logic [SEQ_WIDTH-1:0] SEQ_MAX = '1;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Register state
    wwd_state_type   state_q, state_d;
    wwd_func_type    func_q, func_d;
    logic            wen_q, wen_d;
    logic [31:0]     fw_q, fw_d;
    logic [31:0]     sw_q, sw_d;
    logic [31:0]     task_signature_first_q, task_signature_first_d;
    logic [31:0]     task_signature_second_q, task_signature_second_d;
    logic            wcfg_q, wcfg_d;
    logic            irq_q, irq_d;
    logic            bad_q, bad_d;
    logic            rst_out_q, rst_out_d;
    logic            bvalid_q, bvalid_d;
    logic [1:0]      bresp_q, bresp_d;
    logic            rvalid_q, rvalid_d;
    logic [1:0]      rresp_q, rresp_d;
    logic [31:0]     rdata_q, rdata_d;

    // Counters
    logic            fw_load, sw_load, seq_load;
    logic [31:0]     fw_val, sw_val;
    logic            fw_zero, sw_zero, seq_zero;
    logic [SEQ_WIDTH-1:0] seq_val;

    // Decoded events
    logic            wr_go, rd_go;
    logic [31:0]     wr_merged;
    logic            ctrl_wr, kick_req, dis_req, enable_req;
    logic            bad_evt, good_evt;
    logic [31:0]     int_point;
    logic [31:0]     status_word;
    logic            wcfg_clr;

    assign wr_go     = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign rd_go     = s_axi_arvalid && !rvalid_q;
    assign ctrl_wr   = wr_go && s_axi_awaddr == WWD_OFS_CTRL && s_axi_wstrb[0];
    assign kick_req  = ctrl_wr && wen_q && s_axi_wdata[WWD_CTRL_KICK];
    assign dis_req   = ctrl_wr && wen_q && !s_axi_wdata[WWD_CTRL_WEN];
    assign enable_req = ctrl_wr && !wen_q && s_axi_wdata[WWD_CTRL_WEN]
                        && (state_q == WWD_IDLE);
    // Wrong-configuration flag clears by write-one unless set again this cycle
    assign wcfg_clr  = wr_go && s_axi_awaddr == WWD_OFS_STAT && s_axi_wstrb[0]
                       && s_axi_wdata[WWD_STAT_WCFG];

    // Interrupt point: byte count shifted into the selected byte segment
    assign int_point = {24'h00_0000, func_q.second_byte_count}
                       << {func_q.byte_segment_select, 3'b000}; // [R8]

    // Classify restart and disable attempts, and the second window timeout
    always_comb begin
        bad_evt  = 1'b0;
        good_evt = 1'b0;
        if (state_q == WWD_FIRST && (kick_req || dis_req)) begin
            bad_evt = 1'b1; // [R21]
        end else if (state_q == WWD_SECOND) begin
            if (kick_req || dis_req) begin
                // Signatures are only looked at here, never on their writes
                if (func_q.sequence_monitor_enable && task_signature_first_q != task_signature_second_q) begin // [R13] [R15] [R20]
                    bad_evt = 1'b1; // [R14]
                end else begin
                    good_evt = 1'b1; // [R14]
                end
            end else if (sw_zero && !sw_load) begin
                bad_evt = 1'b1; // [R10]
            end
        end
    end

    // Watchdog sequencing
    always_comb begin
        state_d   = state_q;
        wen_d     = wen_q;
        wcfg_d    = wcfg_q && !wcfg_clr;
        bad_d     = bad_q;
        rst_out_d = rst_out_q;
        fw_load   = 1'b0;
        sw_load   = 1'b0;
        seq_load  = 1'b0;
        if (ctrl_wr && !wen_q && s_axi_wdata[WWD_CTRL_WEN] && state_q == WWD_IDLE) begin
            wen_d = 1'b1;
        end
        case (state_q)
            WWD_IDLE: begin
                if (enable_req) begin
                    if (sw_q == WWD_RST_WORD) begin
                        wcfg_d = 1'b1; // [R11]
                        wen_d  = 1'b0; // [R11]
                    end else begin
                        state_d = WWD_FIRST;
                        fw_load = 1'b1; // [R2]
                    end
                end
            end
            WWD_FIRST: begin
                if (bad_evt) begin
                    bad_d = 1'b1;
                end else if (fw_zero && !fw_load) begin
                    // A zero first count lands here one cycle after the load
                    state_d = WWD_SECOND; // [R3] [R4]
                    sw_load = 1'b1; // [R7]
                end
            end
            WWD_SECOND: begin
                if (bad_evt) begin
                    bad_d = 1'b1; // [R9]
                end else if (good_evt) begin
                    if (dis_req && !kick_req && !func_q.disable_protection) begin
                        state_d = WWD_IDLE; // [R9]
                        wen_d   = 1'b0;
                    end else begin
                        state_d = WWD_FIRST; // [R9]
                        fw_load = 1'b1;
                    end
                end
            end
            WWD_DELAY: begin
                if (!func_q.sequence_timer_enable || seq_zero) begin
                    state_d   = WWD_HALTED;
                    rst_out_d = 1'b1; // [R19]
                end
            end
            WWD_HALTED: begin
                rst_out_d = 1'b1;
            end
            default: begin
                state_d = WWD_IDLE;
            end
        endcase
        // Any bad event stops the windows and leads to the reset
        if (bad_evt) begin
            wen_d = 1'b0;
            if (func_q.sequence_timer_enable) begin
                state_d  = WWD_DELAY; // [R18] [R19]
                seq_load = 1'b1;
            end else begin
                state_d   = WWD_HALTED;
                rst_out_d = 1'b1;
            end
        end
        // Free-running timer reloads from its top on expiry
        if (func_q.sequence_timer_enable && seq_zero && state_q != WWD_DELAY) begin
            seq_load = 1'b1; // [R16]
        end
    end

    // Register writes and status flags
    always_comb begin
        wr_merged = WWD_RST_WORD;
        func_d    = func_q;
        fw_d      = fw_q;
        sw_d      = sw_q;
        task_signature_first_d    = task_signature_first_q;
        task_signature_second_d    = task_signature_second_q;
        irq_d     = irq_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_go) begin
            bvalid_d = 1'b1;
            bresp_d  = WWD_RESP_OKAY;
            if (s_axi_awaddr == WWD_OFS_CTRL) begin
                wr_merged = WWD_RST_WORD;
            end else if (s_axi_awaddr == WWD_OFS_STAT) begin
                wr_merged = WWD_RST_WORD;
            end else if (s_axi_awaddr == WWD_OFS_FUNC) begin
                wr_merged = merge({8'h00, func_q.second_byte_count, 6'h00,
                                   func_q.byte_segment_select, 3'h0,
                                   func_q.sequence_timer_enable,
                                   func_q.sequence_monitor_enable, 2'h0,
                                   func_q.disable_protection}, s_axi_wdata, s_axi_wstrb);
                func_d.second_byte_count       = wr_merged[WWD_FUNC_SBC_LSB +: 8];
                func_d.byte_segment_select     = wr_merged[WWD_FUNC_BSS_LSB +: 2];
                func_d.sequence_timer_enable   = wr_merged[WWD_FUNC_SST];
                func_d.sequence_monitor_enable = wr_merged[WWD_FUNC_PSM];
                func_d.disable_protection      = wr_merged[WWD_FUNC_DP];
            end else if (s_axi_awaddr == WWD_OFS_FWR) begin
                if (!wen_q) begin
                    fw_d = merge(fw_q, s_axi_wdata, s_axi_wstrb); // [R1] [R22]
                end
            end else if (s_axi_awaddr == WWD_OFS_SWR) begin
                if (!wen_q) begin
                    sw_d = merge(sw_q, s_axi_wdata, s_axi_wstrb); // [R6] [R22]
                end
            end else if (s_axi_awaddr == WWD_OFS_TASK_SIGNATURE_FIRST) begin
                task_signature_first_d = merge(task_signature_first_q, s_axi_wdata, s_axi_wstrb);
            end else if (s_axi_awaddr == WWD_OFS_TASK_SIGNATURE_SECOND) begin
                task_signature_second_d = merge(task_signature_second_q, s_axi_wdata, s_axi_wstrb);
            end else if (s_axi_awaddr == WWD_OFS_STR) begin
                wr_merged = WWD_RST_WORD; // [R23]
            end else begin
                bresp_d = WWD_RESP_DECERR;
            end
        end
        // Write-one-to-clear of the interrupt flag; a new set wins
        if (wr_go && s_axi_awaddr == WWD_OFS_STAT && s_axi_wstrb[0]
            && s_axi_wdata[WWD_STAT_IRQ]) begin
            irq_d = 1'b0;
        end
        if (state_q == WWD_SECOND && !sw_load && sw_val == int_point) begin
            irq_d = 1'b1; // [R8]
        end
    end

    assign status_word = {27'h000_0000, rst_out_q, bad_q, irq_q,
                          state_q == WWD_SECOND, wcfg_q};

    // Read channel
    always_comb begin
        rvalid_d = rvalid_q;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (rd_go) begin
            rvalid_d = 1'b1;
            rresp_d  = WWD_RESP_OKAY;
            rdata_d  = WWD_RST_WORD;
            if (s_axi_araddr == WWD_OFS_CTRL) begin
                rdata_d[WWD_CTRL_WEN] = wen_q;
            end else if (s_axi_araddr == WWD_OFS_STAT) begin
                rdata_d = status_word;
            end else if (s_axi_araddr == WWD_OFS_FUNC) begin
                rdata_d[WWD_FUNC_SBC_LSB +: 8] = func_q.second_byte_count;
                rdata_d[WWD_FUNC_BSS_LSB +: 2] = func_q.byte_segment_select;
                rdata_d[WWD_FUNC_SST]          = func_q.sequence_timer_enable;
                rdata_d[WWD_FUNC_PSM]          = func_q.sequence_monitor_enable;
                rdata_d[WWD_FUNC_DP]           = func_q.disable_protection;
            end else if (s_axi_araddr == WWD_OFS_FWR) begin
                rdata_d = fw_q;
            end else if (s_axi_araddr == WWD_OFS_SWR) begin
                rdata_d = sw_q;
            end else if (s_axi_araddr == WWD_OFS_TASK_SIGNATURE_FIRST) begin
                rdata_d = task_signature_first_q;
            end else if (s_axi_araddr == WWD_OFS_TASK_SIGNATURE_SECOND) begin
                rdata_d = task_signature_second_q;
            end else if (s_axi_araddr == WWD_OFS_STR) begin
                rdata_d[SEQ_WIDTH-1:0] = seq_val; // [R16]
            end else begin
                rresp_d = WWD_RESP_DECERR;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q   <= WWD_IDLE;
            func_q    <= WWD_FUNC_RST;
            wen_q     <= 1'b0;
            fw_q      <= WWD_RST_WORD;
            sw_q      <= WWD_RST_WORD;
            task_signature_first_q    <= WWD_RST_WORD;
            task_signature_second_q    <= WWD_RST_WORD;
            wcfg_q    <= 1'b0;
            irq_q     <= 1'b0;
            bad_q     <= 1'b0;
            rst_out_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= WWD_RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= WWD_RESP_OKAY;
            rdata_q   <= WWD_RST_WORD;
        end else begin
            state_q   <= state_d;
            func_q    <= func_d;
            wen_q     <= wen_d;
            fw_q      <= fw_d;
            sw_q      <= sw_d;
            task_signature_first_q    <= task_signature_first_d;
            task_signature_second_q    <= task_signature_second_d;
            wcfg_q    <= wcfg_d;
            irq_q     <= irq_d;
            bad_q     <= bad_d;
            rst_out_q <= rst_out_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    wwd_down_counter #(.W(32)) u_first_window (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .load       (fw_load),
        .load_value (fw_q),
        .count_en   (state_q == WWD_FIRST), // [R2]
        .value      (fw_val),
        .at_zero    (fw_zero)
    );

    wwd_down_counter #(.W(32)) u_second_window (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .load       (sw_load),
        .load_value (sw_q),
        .count_en   (state_q == WWD_SECOND), // [R7]
        .value      (sw_val),
        .at_zero    (sw_zero)
    );

    wwd_down_counter #(.W(SEQ_WIDTH)) u_sequence_timer ( // [R17]
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .load       (seq_load),
        .load_value (SEQ_MAX),
        .count_en   (func_q.sequence_timer_enable), // [R18]
        .value      (seq_val),
        .at_zero    (seq_zero)
    );

    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = rd_go;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign wdt_interrupt = irq_q;
    assign wdt_reset     = rst_out_q;
    assign second_window = (state_q == WWD_SECOND);

endmodule

// ===== hdl/wwd_pkg.sv
// Shared constants, field layouts and types for the window watchdog timing block
// Summary of operation
// [R1] First window count changes only while the window enable bit is clear.
// [R2] First window runs as a down-counter from the programmed count to zero.
// [R3] When the first window completes, the second window starts at once.
// [R4] A first window count of zero skips the closed window entirely; the code still spends one cycle in the first window.
// [R5] Software should program a non-zero first window count of fifteen or more.
// [R6] Second window count changes only while the window enable bit is clear.
// [R7] Second window runs as a down-counter from the programmed count to zero.
// [R8] Interrupt point comes from second window count, segment select and byte count.
// [R9] A good or bad event ends the second window immediately.
// [R10] Second window timeout without any event counts as a bad event.
// [R11] Second window count of zero flags wrong configuration and clears enable.
// [R12] Software should choose a second window long enough for its kick writes.
// [R13] Task signatures take effect only when the sequence monitor is enabled.
// [R14] At the kick, unequal signatures are a bad event, equal ones good.
// [R15] Signature writes are not watched; they are compared only at the kick; the code also compares them at a disable in the second window.
// [R16] Read-only sequence timer counts down from two to the width minus one.
// [R17] Sequence timer width is a build parameter from eight to thirty-one.
// [R18] Sequence timer runs only while enabled and delays the watchdog reset.
// [R19] With the sequence timer enabled, the reset waits for its count to expire.
// [R20] Signature comparison happens only with the sequence monitor enabled.
// [R21] Kick or disable in the first window is bad; the disable is refused.
// [R22] Window count writes while enabled answer OKAY and leave the value unchanged.
// [R23] Writes to the sequence timer count register are accepted and ignored.
package wwd_pkg;

    localparam int          WWD_ADDR_W        = 6;
    localparam int          WWD_DATA_W        = 32;
    localparam int          WWD_SEQ_WIDTH_DEF = 16;
    localparam int          WWD_SEQ_WIDTH_MIN = 8;
    localparam int          WWD_SEQ_WIDTH_MAX = 31;

    // Register byte offsets
    localparam logic [5:0]  WWD_OFS_CTRL      = 6'h0C;
    localparam logic [5:0]  WWD_OFS_STAT      = 6'h10;
    localparam logic [5:0]  WWD_OFS_FUNC      = 6'h14;
    localparam logic [5:0]  WWD_OFS_FWR       = 6'h18;
    localparam logic [5:0]  WWD_OFS_SWR       = 6'h1C;
    localparam logic [5:0]  WWD_OFS_TASK_SIGNATURE_FIRST      = 6'h20;
    localparam logic [5:0]  WWD_OFS_TASK_SIGNATURE_SECOND      = 6'h24;
    localparam logic [5:0]  WWD_OFS_STR       = 6'h28;

    // Control register fields
    localparam int          WWD_CTRL_WEN      = 0;
    localparam int          WWD_CTRL_KICK     = 1;

    // Status register fields
    localparam int          WWD_STAT_WCFG     = 0;
    localparam int          WWD_STAT_SECOND   = 1;
    localparam int          WWD_STAT_IRQ      = 2;
    localparam int          WWD_STAT_BAD      = 3;
    localparam int          WWD_STAT_RESET    = 4;

    // Function register fields
    localparam int          WWD_FUNC_DP       = 0;
    localparam int          WWD_FUNC_PSM      = 3;
    localparam int          WWD_FUNC_SST      = 4;
    localparam int          WWD_FUNC_BSS_LSB  = 8;
    localparam int          WWD_FUNC_SBC_LSB  = 16;

    // Reset values
    localparam logic [31:0] WWD_RST_WORD      = 32'h0000_0000;

    // Bus responses
    localparam logic [1:0]  WWD_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  WWD_RESP_DECERR   = 2'h3;

    typedef struct packed {
        logic [7:0] second_byte_count;
        logic [1:0] byte_segment_select;
        logic       sequence_timer_enable;
        logic       sequence_monitor_enable;
        logic       disable_protection;
    } wwd_func_type;

    localparam wwd_func_type WWD_FUNC_RST = '{8'h00, 2'h0, 1'b0, 1'b0, 1'b0};

    typedef enum logic [4:0] {
        WWD_IDLE   = 5'b00001,
        WWD_FIRST  = 5'b00010,
        WWD_SECOND = 5'b00100,
        WWD_DELAY  = 5'b01000,
        WWD_HALTED = 5'b10000
    } wwd_state_type;

endpackage

// ===== hdl/wwd_down_counter.sv
// Loadable down-counter used for the window and sequence timers
`timescale 1ns/1ns
module wwd_down_counter #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    input  wire logic         count_en,
    // State
    output logic      [W-1:0] value,
    output logic              at_zero
);

    logic [W-1:0] value_q;
    logic [W-1:0] value_d;

    // Load takes priority over counting; the count holds at zero
    always_comb begin
        value_d = value_q;
        if (load) begin
            value_d = load_value;
        end else if (count_en && value_q != '0) begin
            value_d = value_q - W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            value_q <= '0;
        end else begin
            value_q <= value_d;
        end
    end

    assign value   = value_q;
    assign at_zero = (value_q == '0);

endmodule

// ===== tb/wwd_timing_regs_sva.sv
// Bus handshake and watchdog output checks for the timing block
`timescale 1ns/1ns
module wwd_timing_regs_sva (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Watchdog outputs
    input wire logic        wdt_interrupt,
    input wire logic        wdt_reset,
    input wire logic        second_window
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wr_accept_a: assert property (
        s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
        && s_axi_wready == s_axi_awready) else $error("write accept wrong");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write answer missing");
    wr_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer stuck");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer stuck");
    reset_hold_a: assert property (wdt_reset |=> wdt_reset) else $error("reset dropped");
    reset_ends_a: assert property ($rose(wdt_reset) |-> !second_window)
        else $error("window open at reset");
    irq_second_a: assert property ($rose(wdt_interrupt) |-> $past(second_window))
        else $error("interrupt outside window");
endmodule
bind wwd_timing_regs wwd_timing_regs_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wdt_interrupt(wdt_interrupt), .wdt_reset(wdt_reset), .second_window(second_window));

// ===== tb/test_wwd_timing_regs.sv
// Register-level test of the window watchdog timing block
`timescale 1ns/1ns
module test_wwd_timing_regs import wwd_pkg::*;;
    logic        sys_clk;
    logic        rst_n;
    logic [5:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [1:0]  bresp;
    logic        bvalid;
    logic [5:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        irq;
    logic        wdt_rst;
    logic        sec_win;
    logic [31:0] rd;
    logic [31:0] rd1;
    logic [1:0]  rsp;
    int          err_count;
    int          num_checks;
    int          cyc;
    int          t_take;
    int          t0;
    wwd_timing_regs #(.SEQ_WIDTH(8)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(awvalid), .s_axi_wready(),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .wdt_interrupt(irq), .wdt_reset(wdt_rst), .second_window(sec_win));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
    endtask
    // Address and data offered together; the answer is read one cycle later
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        int n;
        @(negedge sys_clk);
        awaddr = a;
        wdata = d;
        awvalid = 1'b1;
        n = 0;
        @(posedge sys_clk);
        while (awready !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        t_take = cyc + 1;
        @(negedge sys_clk);
        awvalid = 1'b0;
        chk(bvalid, 1'b1);
        rsp = bresp;
    endtask
    task automatic rdr(input logic [5:0] a);
        int n;
        @(negedge sys_clk);
        araddr = a;
        arvalid = 1'b1;
        n = 0;
        @(posedge sys_clk);
        while (arready !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        arvalid = 1'b0;
        chk(rvalid, 1'b1);
        rd = rdata;
        rsp = rresp;
    endtask
    // Waits for window, interrupt or reset output to reach a level
    task automatic wt(input int sel, input logic lvl);
        int n;
        n = 0;
        while ((sel == 0 ? sec_win : sel == 1 ? irq : wdt_rst) !== lvl && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        chk(n < 2000, 1'b1);
    endtask
    task automatic cfg(input logic [31:0] fw, sw, fn, sig);
        wr(WWD_OFS_FWR, fw);
        wr(WWD_OFS_SWR, sw);
        wr(WWD_OFS_FUNC, fn);
        wr(WWD_OFS_TASK_SIGNATURE_FIRST, 32'hA5);
        wr(WWD_OFS_TASK_SIGNATURE_SECOND, sig);
        wr(WWD_OFS_CTRL, 32'h1);
        t0 = t_take;
    endtask
    initial begin
        #2_000_000;
        err_count++;
        finish_test();
    end
    initial begin
        rst_n = 1'b0;
        awvalid = 1'b0;
        arvalid = 1'b0;
        awaddr = 6'h00;
        araddr = 6'h00;
        wdata = 32'h0;
        err_count = 0;
        num_checks = 0;
        cyc = 0;
        do_reset();
        for (int a = 24; a <= 40; a += 4) begin
            rdr(a[5:0]);
            chk(rd, WWD_RST_WORD);
        end
        wr(WWD_OFS_STR, 32'hFFFF_FFFF);
        chk(rsp, WWD_RESP_OKAY);
        rdr(WWD_OFS_STR);
        chk(rd, 32'h0);
        wr(6'h3C, 32'h1);
        chk(rsp, WWD_RESP_DECERR);
        rdr(6'h3C);
        chk({rsp, rd[29:0]}, {WWD_RESP_DECERR, 30'h0});
        wr(WWD_OFS_CTRL, 32'h1);
        rdr(WWD_OFS_STAT);
        chk(rd[0], 1'b1);
        rdr(WWD_OFS_CTRL);
        chk(rd[0], 1'b0);
        wr(WWD_OFS_STAT, 32'h1);
        rdr(WWD_OFS_STAT);
        chk(rd[0], 1'b0);
        // Matching signatures, monitor on, interrupt at count 0x0A
        cfg(32'h0F, 32'h28, 32'h000A_0008, 32'hA5);
        wr(WWD_OFS_FWR, 32'h77);
        chk(rsp, WWD_RESP_OKAY);
        wr(WWD_OFS_SWR, 32'h77);
        rdr(WWD_OFS_FWR);
        chk(rd, 32'h0F);
        rdr(WWD_OFS_SWR);
        chk(rd, 32'h28);
        wt(0, 1'b1);
        chk(cyc, t0 + 32'h10);
        t0 = cyc;
        wt(1, 1'b1);
        chk(cyc, t0 + 32'h1F);
        wr(WWD_OFS_STAT, 32'h4);
        chk(irq, 1'b0);
        wr(WWD_OFS_CTRL, 32'h3);
        chk({sec_win, wdt_rst}, 2'b00);
        wr(WWD_OFS_TASK_SIGNATURE_SECOND, 32'h5A);
        chk(wdt_rst, 1'b0);
        wt(0, 1'b1);
        wr(WWD_OFS_CTRL, 32'h3);
        chk(wdt_rst, 1'b1);
        do_reset();
        // Monitor off: mismatch ignored, then disable in first window
        cfg(32'h0F, 32'h28, 32'h0, 32'h5A);
        wt(0, 1'b1);
        wr(WWD_OFS_CTRL, 32'h3);
        chk(wdt_rst, 1'b0);
        wr(WWD_OFS_CTRL, 32'h0);
        chk(wdt_rst, 1'b1);
        do_reset();
        // Zero first window count, one-cycle closed window, timeout, delayed reset
        cfg(32'h0, 32'h14, 32'h10, 32'hA5);
        wt(0, 1'b1);
        chk(cyc, t0 + 32'h1);
        rdr(WWD_OFS_STR);
        rd1 = rd;
        rdr(WWD_OFS_STR);
        chk({rd[31:8], rd == rd1}, 25'h0);
        wt(0, 1'b0);
        t0 = cyc;
        repeat (250) @(negedge sys_clk);
        chk(wdt_rst, 1'b0);
        wt(2, 1'b1);
        chk(cyc - t0, 32'h100);
        rdr(WWD_OFS_STAT);
        chk(rd[4:3], 2'b11);
        finish_test();
    end
endmodule
